//--- fsp_top.sv
// Flash security and protection logic: lock decode, debug gating,
// backdoor key check, protection register that software can only grow, violation flags
// and EEPROM page select.
// Assumes the nonvolatile bytes are stable from reset release on, and
// that flash writes and register strobes are synchronous to i_clk.
//
// How it works
// - Lock code 1:0 means unsecured and every other code, erased 1:1 included, means secured.
// - The debug module enable is held off while the part is secured.
// - Background access stays open when secured, but active background mode needs the pin low at reset.
// - With backdoor_enable at 0 the key window cannot open, so only a full erase unlocks.
// - Key range writes are key bytes while key_write_enable is set and flash commands otherwise.
// - Clearing the enable after eight matching bytes forces the lock to 1:0 until reset.
// - Key bytes are taken only from code in secure memory, never from debug commands alone.
// - Only debug commands may shrink protection; application writes cannot.
// - A blank check that finds flash erased releases security until reset.
// - The option and key bytes sit in the top protected block, so protecting it guards them.
// - The page select bit maps page 0 or page 1 into the foreground, never both.
// - The protection register loads from the nonvolatile protection byte on the first clock after reset release.
// - The protection register always reads back and software can only enlarge it.
// - A program or erase to a protected address is blocked and sets the violation flag.
// - Mass erase is refused while any sector is protected.
`timescale 1ns/1ns
module fsp_top (
  input wire logic i_clk,                         // System bus clock
  input wire logic i_nrst,                        // Async reset, active low
  input wire fsp_pkg::fsp_bus_t i_bus,            // Register port request
  input wire fsp_pkg::fsp_fwr_t i_fwr,            // Flash array write
  input wire logic i_mass_req,                    // Mass erase request pulse
  input wire logic i_blank_ok,                    // Blank check found all erased
  input wire logic i_dbg_req,                     // Debug module enable request
  input wire logic i_bgnd_req,                    // Background mode entry request
  input wire logic i_pin_low_at_rst,              // debug_pin low at reset rise
  input wire logic [7:0] i_nv_opt,                // nonvolatile_options_byte
  input wire logic [7:0] i_nv_prot,               // nonvolatile_protection_byte
  input wire logic [fsp_pkg::FSP_KEY_W-1:0] i_nv_key, // backdoor_key_locations
  output logic [7:0] o_rdata,                     // Read data, cycle after strobe
  output logic o_irq,                             // Level interrupt
  output logic o_secured,                         // Part secured
  output logic o_dbg_en,                          // Debug module enabled
  output logic o_bgnd,                            // Active background mode
  output logic o_page_sel,                        // Foreground EEPROM page
  output logic o_cmd_go,                          // Flash command start pulse
  output logic o_mass_go                          // Mass erase start pulse
);

  ////////////////////////////////////////////////////////////////////////
  // State and helpers

  fsp_pkg::fsp_state_t st_q;
  fsp_pkg::fsp_state_t st_d;

  // Address falls in the protected top region of prot 256-byte sectors
  function automatic logic prot_hit(input logic [15:0] a, input logic [7:0] p);
    logic [8:0] sum;
    sum = {1'b0, a[fsp_pkg::FSP_SECT_HI:fsp_pkg::FSP_SECT_LO]} + {1'b0, p};
    prot_hit = (sum > fsp_pkg::FSP_SECT_TOP);
  endfunction

  logic key_rng;
  logic bk_en;
  logic cfg_wr;
  logic key_close;
  logic key_wr;
  logic [2:0] kidx;
  logic [7:0] key_byte;

  // Decode of the key window; the key range is fixed, not relocatable
  assign key_rng = (i_fwr.addr >= fsp_pkg::FSP_KEY_BASE) && (i_fwr.addr <= fsp_pkg::FSP_KEY_LAST);
  assign bk_en = i_nv_opt[fsp_pkg::FSP_OPT_BKEN];
  assign cfg_wr = i_bus.wr && (i_bus.addr == fsp_pkg::FSP_A_CFG);
  assign key_close = cfg_wr && (st_q.ks == fsp_pkg::FSP_KS_ARMED)
                     && !i_bus.wdata[fsp_pkg::FSP_CFG_KEYW];
  assign key_wr = i_fwr.vld && key_rng && (st_q.ks == fsp_pkg::FSP_KS_ARMED);
  assign kidx = i_fwr.addr[2:0];
  assign key_byte = i_nv_key[{kidx, 3'h0} +: 8];

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Event count, declared ahead of the process that sizes its vectors by it
  localparam int FSP_NEV_LOC = fsp_pkg::FSP_NEV;

  always_comb
  begin
    logic [FSP_NEV_LOC-1:0] ev;
    logic [FSP_NEV_LOC-1:0] clr;
    logic viol;
    ev = '0;
    clr = '0;
    viol = 1'b0;
    st_d = st_q;
    st_d.cmd_go = 1'b0;
    st_d.mass_go = 1'b0;
    st_d.kprev = 1'b0;
    st_d.rdata = fsp_pkg::FSP_BYTE_RST;

    // First cycle after reset release takes the nonvolatile bytes
    if (!st_q.loaded)
    begin
      st_d.loaded = 1'b1;
      st_d.lock = i_nv_opt[fsp_pkg::FSP_LOCK_HI:fsp_pkg::FSP_LOCK_LO];
      st_d.prot = i_nv_prot;
      // Pin strap is the only way into background mode when secured
      st_d.bgnd = i_pin_low_at_rst;
    end
    else
    begin
      // Register writes
      if (i_bus.wr)
      begin
        case (i_bus.addr)
          fsp_pkg::FSP_A_CFG:
          begin
            st_d.page = i_bus.wdata[fsp_pkg::FSP_CFG_PAGE];
            // Window cannot open while the backdoor is disabled
            if (i_bus.wdata[fsp_pkg::FSP_CFG_KEYW] && bk_en)
            begin
              if (st_q.ks == fsp_pkg::FSP_KS_IDLE)
              begin
                st_d.kcnt = '0;
                st_d.kbad = 1'b0;
              end
              st_d.ks = fsp_pkg::FSP_KS_ARMED;
            end
            else
              st_d.ks = fsp_pkg::FSP_KS_IDLE;
          end
          fsp_pkg::FSP_A_PROT:
          begin
            // Debug may relax; software may only grow the region
            if (i_bus.bdm || (i_bus.wdata > st_q.prot))
              st_d.prot = i_bus.wdata;
          end
          fsp_pkg::FSP_A_FLASH_STATUS_REG:
            if (i_bus.wdata[fsp_pkg::FSP_FLASH_STATUS_REG_VIOL])
              st_d.fviol = 1'b0;
          fsp_pkg::FSP_A_ISTS:
            clr = i_bus.wdata[FSP_NEV_LOC-1:0];
          fsp_pkg::FSP_A_IMSK:
            st_d.imsk = i_bus.wdata[FSP_NEV_LOC-1:0];
          default:
            st_d.imsk = st_q.imsk;
        endcase
      end

      // Key byte collection: in order, from secure code, not adjacent
      if (key_wr)
      begin
        st_d.kprev = 1'b1;
        if (!i_fwr.secure || i_fwr.bdm || st_q.kprev
            || (kidx != st_q.kcnt[2:0]) || (st_q.kcnt >= fsp_pkg::FSP_KEY_BYTES)
            || (i_fwr.data != key_byte))
          st_d.kbad = 1'b1;
        if (st_q.kcnt < fsp_pkg::FSP_KEY_BYTES)
          st_d.kcnt = st_q.kcnt + 4'h1;
      end

      // Closing the window decides the unlock
      if (key_close)
      begin
        if (!st_q.kbad && (st_q.kcnt == fsp_pkg::FSP_KEY_BYTES) && bk_en)
        begin
          st_d.lock = fsp_pkg::FSP_LOCK_OPEN;
          ev[fsp_pkg::FSP_EV_OPEN] = 1'b1;
        end
        else
          ev[fsp_pkg::FSP_EV_KFAIL] = 1'b1;
      end

      // Erased flash releases security
      if (i_blank_ok)
      begin
        st_d.lock = fsp_pkg::FSP_LOCK_OPEN;
        ev[fsp_pkg::FSP_EV_OPEN] = 1'b1;
      end

      // Program/erase start, blocked over protected sectors; the
      // option and key bytes share the top block with the vectors
      if (i_fwr.vld && !key_wr)
      begin
        if (prot_hit(i_fwr.addr, st_q.prot))
          viol = 1'b1;
        else
          st_d.cmd_go = 1'b1;
      end
      if (i_mass_req)
      begin
        if (st_q.prot != fsp_pkg::FSP_BYTE_RST)
          viol = 1'b1;
        else
          st_d.mass_go = 1'b1;
      end

      // Background entry after reset only while unsecured
      if (i_bgnd_req && (st_q.lock == fsp_pkg::FSP_LOCK_OPEN))
        st_d.bgnd = 1'b1;
    end

    // Sticky flags: a new event wins over a same-cycle clear
    ev[fsp_pkg::FSP_EV_VIOL] = viol;
    if (viol)
      st_d.fviol = 1'b1;
    st_d.ists = (st_q.ists & ~clr) | ev;

    // Derived outputs, registered
    st_d.secd = (st_d.lock != fsp_pkg::FSP_LOCK_OPEN);
    st_d.dbg = i_dbg_req && !st_d.secd;
    st_d.irq = |(st_d.ists & st_d.imsk);

    // Read data stands in the cycle after the strobe only
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        fsp_pkg::FSP_A_CFG:
        begin
          st_d.rdata[fsp_pkg::FSP_CFG_PAGE] = st_q.page;
          st_d.rdata[fsp_pkg::FSP_CFG_KEYW] = (st_q.ks == fsp_pkg::FSP_KS_ARMED);
        end
        fsp_pkg::FSP_A_PROT:
          st_d.rdata = st_q.prot;
        fsp_pkg::FSP_A_FLASH_STATUS_REG:
          st_d.rdata[fsp_pkg::FSP_FLASH_STATUS_REG_VIOL] = st_q.fviol;
        fsp_pkg::FSP_A_OPT:
        begin
          st_d.rdata[fsp_pkg::FSP_OPT_BKEN] = bk_en;
          st_d.rdata[fsp_pkg::FSP_OPT_SECD] = st_q.secd;
          st_d.rdata[fsp_pkg::FSP_LOCK_HI:fsp_pkg::FSP_LOCK_LO] = st_q.lock;
        end
        fsp_pkg::FSP_A_ISTS:
          st_d.rdata[FSP_NEV_LOC-1:0] = st_q.ists;
        fsp_pkg::FSP_A_IMSK:
          st_d.rdata[FSP_NEV_LOC-1:0] = st_q.imsk;
        default:
          st_d.rdata = fsp_pkg::FSP_BYTE_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; reset leaves the part secured and fully protected
  // until the nonvolatile bytes are taken on the first clock

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= '0;
      st_q.lock <= fsp_pkg::FSP_LOCK_RST;
      st_q.secd <= 1'b1;
      st_q.prot <= '1;
    end
    else
      st_q <= st_d;
  end

  assign o_rdata = st_q.rdata;
  assign o_irq = st_q.irq;
  assign o_secured = st_q.secd;
  assign o_dbg_en = st_q.dbg;
  assign o_bgnd = st_q.bgnd;
  assign o_page_sel = st_q.page;
  assign o_cmd_go = st_q.cmd_go;
  assign o_mass_go = st_q.mass_go;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  chk_lock_decode: assert property (
    st_q.loaded |-> (o_secured == (st_q.lock != fsp_pkg::FSP_LOCK_OPEN)))
    else $error("secured output disagrees with lock code");

  chk_debug_gate: assert property (
    o_secured |-> !o_dbg_en)
    else $error("debug enabled while secured");

  chk_bgnd_secure: assert property (
    (st_q.loaded && o_secured && !o_bgnd) |=> !o_bgnd)
    else $error("background mode entered while secured");

  chk_no_window: assert property (
    (cfg_wr && !i_nv_opt[fsp_pkg::FSP_OPT_BKEN]) |=> (st_q.ks == fsp_pkg::FSP_KS_IDLE))
    else $error("key window opened with backdoor disabled");

  chk_key_not_cmd: assert property (
    key_wr |=> !o_cmd_go)
    else $error("key byte started a flash command");

  chk_unlock_good: assert property (
    (key_close && !st_q.kbad && st_q.kcnt == fsp_pkg::FSP_KEY_BYTES && bk_en)
    |=> !o_secured ##1 !o_secured)
    else $error("good key did not release security");

  chk_unlock_bad: assert property (
    (key_close && st_q.kbad && !i_blank_ok) |=> $stable(st_q.lock))
    else $error("bad key changed the lock");

  chk_key_source: assert property (
    (key_wr && !i_fwr.secure) |=> st_q.kbad)
    else $error("key byte accepted from non-secure source");

  chk_prot_grow: assert property (
    (st_q.loaded && i_bus.wr && !i_bus.bdm && i_bus.addr == fsp_pkg::FSP_A_PROT)
    |=> (st_q.prot >= $past(st_q.prot)))
    else $error("software shrank protection");

  chk_blank_open: assert property (
    (st_q.loaded && i_blank_ok) |=> !o_secured)
    else $error("blank check did not release security");

  chk_viol_block: assert property (
    (st_q.loaded && i_fwr.vld && !key_wr && prot_hit(i_fwr.addr, st_q.prot))
    |=> (!o_cmd_go && st_q.fviol && st_q.ists[fsp_pkg::FSP_EV_VIOL]))
    else $error("protected write not blocked");

  chk_mass_refuse: assert property (
    (i_mass_req && st_q.prot != fsp_pkg::FSP_BYTE_RST) |=> !o_mass_go)
    else $error("mass erase with protection set");

  // Loaded values are looked at on the edge after the load; the edge that
  // releases reset still sees the reset image and is left out on purpose
  chk_load_prot: assert property (
    $rose(st_q.loaded) |-> (st_q.prot == $past(i_nv_prot)))
    else $error("protection not loaded from nonvolatile byte");

  chk_bgnd_strap: assert property (
    $rose(st_q.loaded) |-> (o_bgnd == $past(i_pin_low_at_rst)))
    else $error("background mode does not follow the reset strap");

  // Accepted starts, read-back and sticky flags
  chk_cmd_start: assert property (
    (st_q.loaded && i_fwr.vld && !key_wr && !prot_hit(i_fwr.addr, st_q.prot))
    |=> o_cmd_go)
    else $error("unprotected write did not start a flash command");

  chk_mass_start: assert property (
    (st_q.loaded && i_mass_req && (st_q.prot == fsp_pkg::FSP_BYTE_RST)) |=> o_mass_go)
    else $error("mass erase refused with no protection");

  chk_dbg_open: assert property (
    (st_q.loaded && i_dbg_req && !o_secured) |=> o_dbg_en)
    else $error("debug module not enabled while unsecured");

  chk_page_one: assert property (
    (st_q.loaded && cfg_wr && i_bus.wdata[fsp_pkg::FSP_CFG_PAGE]) |=> o_page_sel)
    else $error("page 1 not selected");

  chk_page_zero: assert property (
    (st_q.loaded && cfg_wr && !i_bus.wdata[fsp_pkg::FSP_CFG_PAGE]) |=> !o_page_sel)
    else $error("page 0 not selected");

  chk_prot_read: assert property (
    (i_bus.rd && (i_bus.addr == fsp_pkg::FSP_A_PROT)) |=> (o_rdata == $past(st_q.prot)))
    else $error("protection read-back differs from the register");

  chk_rdata_idle: assert property (
    !i_bus.rd |=> (o_rdata == fsp_pkg::FSP_BYTE_RST))
    else $error("read data stood longer than one cycle");

  chk_viol_sticky: assert property (
    (st_q.fviol && !(i_bus.wr && (i_bus.addr == fsp_pkg::FSP_A_FLASH_STATUS_REG))) |=> st_q.fviol)
    else $error("violation flag dropped without a clear");

  // Main scenarios
  cov_unlock: cover property (key_close ##1 !o_secured);
  cov_violation: cover property (i_fwr.vld ##1 st_q.fviol);
  cov_grow: cover property ((i_bus.wr && i_bus.addr == fsp_pkg::FSP_A_PROT)
    ##1 $changed(st_q.prot));
  cov_bad_key: cover property (key_close && st_q.kbad);
  cov_blank: cover property (st_q.loaded && o_secured && i_blank_ok);

endmodule

//--- fsp_pkg.sv
// Package for the flash security and protection block: register map,
// field positions, lock encodings and the carrier structs.
// Assumes an 8-bit register port with a 4-bit word index.
package fsp_pkg;

  // Register indices on the register port
  localparam logic [3:0] FSP_A_CFG = 4'h0;   // flash_eeprom_config
  localparam logic [3:0] FSP_A_PROT = 4'h1;  // protection_reg
  localparam logic [3:0] FSP_A_FLASH_STATUS_REG = 4'h2; // flash_status_reg
  localparam logic [3:0] FSP_A_OPT = 4'h3;   // security view
  localparam logic [3:0] FSP_A_ISTS = 4'h4;  // interrupt status
  localparam logic [3:0] FSP_A_IMSK = 4'h5;  // interrupt mask

  // Field positions
  localparam int FSP_CFG_PAGE = 6;   // eeprom_page_select
  localparam int FSP_CFG_KEYW = 5;   // key_write_enable
  localparam int FSP_FLASH_STATUS_REG_VIOL = 5; // protection_violation_flag
  localparam int FSP_OPT_BKEN = 7;   // backdoor_enable in nonvolatile_options_byte
  localparam int FSP_OPT_SECD = 2;   // secured status bit in security view
  localparam int FSP_LOCK_HI = 1;    // lock_state_field upper bit
  localparam int FSP_LOCK_LO = 0;    // lock_state_low_bit

  // Interrupt event bits
  localparam int FSP_EV_VIOL = 0;    // program/erase/mass erase blocked
  localparam int FSP_EV_OPEN = 1;    // security released
  localparam int FSP_EV_KFAIL = 2;   // key sequence rejected
  localparam int FSP_NEV = 3;

  // Values
  localparam logic [1:0] FSP_LOCK_OPEN = 2'h2;  // 1:0 is the only unsecured code
  localparam logic [1:0] FSP_LOCK_RST = 2'h3;   // erased value until loaded
  localparam logic [7:0] FSP_BYTE_RST = 8'h00;
  localparam logic [15:0] FSP_KEY_BASE = 16'hFFB0;
  localparam logic [15:0] FSP_KEY_LAST = 16'hFFB7;
  localparam logic [3:0] FSP_KEY_BYTES = 4'h8;
  localparam int FSP_KEY_W = 64;
  localparam int FSP_SECT_HI = 15;    // protection granule is 256 bytes
  localparam int FSP_SECT_LO = 8;
  localparam logic [8:0] FSP_SECT_TOP = 9'h0FF;

  // Key window state
  typedef enum logic [0:0] {
    FSP_KS_IDLE = 1'b0,
    FSP_KS_ARMED = 1'b1
  } fsp_ks_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic bdm;        // access comes from a background debug command
  } fsp_bus_t;

  // Flash array write from the core or debug controller
  typedef struct packed {
    logic vld;
    logic [15:0] addr;
    logic [7:0] data;
    logic secure;     // executing code lives in secure memory
    logic bdm;        // issued by a background debug command
  } fsp_fwr_t;

  // All state of the block
  typedef struct packed {
    logic loaded;
    logic [1:0] lock;
    logic page;
    fsp_ks_t ks;
    logic [7:0] prot;
    logic fviol;
    logic [FSP_NEV-1:0] ists;
    logic [FSP_NEV-1:0] imsk;
    logic [3:0] kcnt;
    logic kbad;
    logic kprev;
    logic [7:0] rdata;
    logic irq;
    logic secd;
    logic dbg;
    logic bgnd;
    logic cmd_go;
    logic mass_go;
  } fsp_state_t;

endpackage

//--- fsp_core_model.sv
// Partner model: processor core and background debug controller, flash write side.
// Assumes the testbench calls its tasks only after reset has been released.
`timescale 1ns/1ns
module fsp_core_model (
  input wire logic i_clk,                 // System bus clock
  output fsp_pkg::fsp_fwr_t o_fwr,        // Flash array write
  output logic o_mass_req,                // Mass erase request pulse
  output logic o_blank_ok                 // Blank check result pulse
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle values; a released write shows the inverse of its last address and data
  initial
  begin
    o_fwr = '0;
    o_mass_req = 1'b0;
    o_blank_ok = 1'b0;
  end

  // One flash write, held for exactly one edge
  task automatic fwr(input logic [15:0] a, input logic [7:0] d, input logic s, input logic b);
    @(posedge i_clk);
    o_fwr <= '{vld: 1'b1, addr: a, data: d, secure: s, bdm: b};
    @(posedge i_clk);
    o_fwr <= '{vld: 1'b0, addr: ~a, data: ~d, secure: s, bdm: b};
  endtask

  // Eight key bytes, ascending, never on adjacent cycles
  task automatic key_seq(input logic [63:0] k, input logic s);
    for (int i = 0; i < 8; i++)
    begin
      fwr(16'hFFB0 + 16'(i), k[8*i +: 8], s, 1'b0);
    end
  endtask

  // Single-cycle request pulses
  task automatic mass();
    @(posedge i_clk);
    o_mass_req <= 1'b1;
    @(posedge i_clk);
    o_mass_req <= 1'b0;
  endtask

  task automatic blank();
    @(posedge i_clk);
    o_blank_ok <= 1'b1;
    @(posedge i_clk);
    o_blank_ok <= 1'b0;
  endtask
endmodule

//--- flash_security_protection_test.sv
// Self-checking testbench for the flash security and protection block.
// Assumes fsp_pkg and fsp_core_model are compiled first.
`timescale 1ns/1ns
module flash_security_protection_test;
  localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  fsp_pkg::fsp_bus_t bus = '0;
  fsp_pkg::fsp_fwr_t fwr;
  logic mass, blank;
  logic dbg_req = 1'b0;
  logic bgnd_req = 1'b0;
  logic pin_low = 1'b0;
  logic [7:0] nv_opt = 8'h81;
  logic [7:0] nv_prot = 8'h01;
  logic [7:0] rdata;
  logic irq, secured, dbg_en, bgnd, page, cmd_go, mass_go;
  int miscompares = 0;
  int tests_run = 0;
  int ncmd = 0;
  int nmass = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, design and partner
  always #2 i_clk = ~i_clk;

  fsp_top fsp_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus), .i_fwr(fwr),
    .i_mass_req(mass), .i_blank_ok(blank), .i_dbg_req(dbg_req), .i_bgnd_req(bgnd_req),
    .i_pin_low_at_rst(pin_low), .i_nv_opt(nv_opt), .i_nv_prot(nv_prot), .i_nv_key(KEY),
    .o_rdata(rdata), .o_irq(irq), .o_secured(secured), .o_dbg_en(dbg_en), .o_bgnd(bgnd),
    .o_page_sel(page), .o_cmd_go(cmd_go), .o_mass_go(mass_go));

  fsp_core_model fsp_core_model_inst (.i_clk(i_clk), .o_fwr(fwr), .o_mass_req(mass),
    .o_blank_ok(blank));

  // Count start pulses so checks need not hit the exact pulse cycle
  always @(posedge i_clk)
  begin
    if (cmd_go === 1'b1) ncmd++;
    if (mass_go === 1'b1) nmass++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access tasks
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic b);
    @(posedge i_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, bdm: b};
    @(posedge i_clk);
    bus <= '0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, bdm: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    #1 chk(n, rdata, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic pulse_bgnd();
    @(posedge i_clk);
    bgnd_req <= 1'b1;
    @(posedge i_clk);
    bgnd_req <= 1'b0;
  endtask

  // Reset held four cycles; first request waits two edges after release
  task automatic do_reset();
    @(posedge i_clk);
    i_nrst <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    tick(2);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    do_reset();
    chk("secured", secured, 8'h01);
    rd("prot", fsp_pkg::FSP_A_PROT, 8'h01);
    rd("view", fsp_pkg::FSP_A_OPT, 8'h85);
    rd("unmapped", 4'hF, 8'h00);
    $display("test reset done");
    @(posedge i_clk) dbg_req <= 1'b1;
    pulse_bgnd();
    tick(2);
    chk("dbg_en", dbg_en, 8'h00);
    chk("bgnd", bgnd, 8'h00);
    $display("test debug gating done");
    wr(fsp_pkg::FSP_A_PROT, 8'h00, 1'b0);
    rd("prot shrink", fsp_pkg::FSP_A_PROT, 8'h01);
    wr(fsp_pkg::FSP_A_PROT, 8'h03, 1'b0);
    rd("prot grow", fsp_pkg::FSP_A_PROT, 8'h03);
    wr(fsp_pkg::FSP_A_PROT, 8'h01, 1'b1);
    rd("prot debug", fsp_pkg::FSP_A_PROT, 8'h01);
    $display("test protection done");
    fsp_core_model_inst.fwr(16'hFFB0, 8'h5A, 1'b1, 1'b0);
    fsp_core_model_inst.fwr(16'h1000, 8'hA5, 1'b1, 1'b0);
    tick(2);
    chk("cmd count", 8'(ncmd), 8'h01);
    rd("flash_status_reg", fsp_pkg::FSP_A_FLASH_STATUS_REG, 8'h20);
    chk("irq masked", irq, 8'h00);
    wr(fsp_pkg::FSP_A_IMSK, 8'h01, 1'b0);
    tick(1);
    chk("irq", irq, 8'h01);
    wr(fsp_pkg::FSP_A_ISTS, 8'h01, 1'b0);
    wr(fsp_pkg::FSP_A_FLASH_STATUS_REG, 8'h20, 1'b0);
    tick(1);
    chk("irq clear", irq, 8'h00);
    rd("flash_status_reg clear", fsp_pkg::FSP_A_FLASH_STATUS_REG, 8'h00);
    fsp_core_model_inst.mass();
    tick(2);
    chk("mass refused", 8'(nmass), 8'h00);
    rd("ists", fsp_pkg::FSP_A_ISTS, 8'h01);
    wr(fsp_pkg::FSP_A_ISTS, 8'h01, 1'b0);
    wr(fsp_pkg::FSP_A_PROT, 8'h00, 1'b1);
    fsp_core_model_inst.fwr(16'hFFB0, 8'h5A, 1'b1, 1'b0);
    fsp_core_model_inst.mass();
    tick(2);
    chk("cmd key range", 8'(ncmd), 8'h02);
    chk("mass", 8'(nmass), 8'h01);
    $display("test violation done");
    // A wrong byte, then a right key from non-secure code, then the right key
    wr(fsp_pkg::FSP_A_CFG, 8'h20, 1'b0);
    rd("cfg key", fsp_pkg::FSP_A_CFG, 8'h20);
    fsp_core_model_inst.key_seq(KEY ^ 64'h1, 1'b1);
    wr(fsp_pkg::FSP_A_CFG, 8'h00, 1'b0);
    tick(2);
    chk("bad key", secured, 8'h01);
    rd("kfail", fsp_pkg::FSP_A_ISTS, 8'h04);
    wr(fsp_pkg::FSP_A_ISTS, 8'h04, 1'b0);
    wr(fsp_pkg::FSP_A_CFG, 8'h20, 1'b0);
    fsp_core_model_inst.key_seq(KEY, 1'b0);
    wr(fsp_pkg::FSP_A_CFG, 8'h00, 1'b0);
    tick(2);
    chk("insecure src", secured, 8'h01);
    wr(fsp_pkg::FSP_A_CFG, 8'h20, 1'b0);
    fsp_core_model_inst.key_seq(KEY, 1'b1);
    wr(fsp_pkg::FSP_A_CFG, 8'h00, 1'b0);
    tick(2);
    chk("no key cmd", 8'(ncmd), 8'h02);
    chk("unlocked", secured, 8'h00);
    rd("view open", fsp_pkg::FSP_A_OPT, 8'h82);
    chk("dbg open", dbg_en, 8'h01);
    pulse_bgnd();
    tick(2);
    chk("bgnd open", bgnd, 8'h01);
    $display("test backdoor key done");
    wr(fsp_pkg::FSP_A_CFG, 8'h40, 1'b0);
    tick(1);
    chk("page1", page, 8'h01);
    rd("cfg page", fsp_pkg::FSP_A_CFG, 8'h40);
    wr(fsp_pkg::FSP_A_CFG, 8'h00, 1'b0);
    tick(1);
    chk("page0", page, 8'h00);
    $display("test page select done");
    // Erased lock code, backdoor off, pin held low through reset
    @(posedge i_clk) nv_opt <= 8'h03;
    pin_low <= 1'b1;
    do_reset();
    chk("erased lock", secured, 8'h01);
    chk("bgnd at reset", bgnd, 8'h01);
    chk("dbg secured", dbg_en, 8'h00);
    wr(fsp_pkg::FSP_A_CFG, 8'h20, 1'b0);
    rd("key off", fsp_pkg::FSP_A_CFG, 8'h00);
    fsp_core_model_inst.blank();
    tick(2);
    chk("blank", secured, 8'h00);
    $display("test erased part done");
    end_of_test();
  end
endmodule
